/* rtl/spm_pkg.sv */
// Constants and carrier types for the strap latch and pin function mux.
package spm_pkg;
   // Register byte addresses on the AXI4-Lite bus.
   localparam logic [7:0] CFG_ADDR = 8'h70;
   localparam logic [7:0] USB_ADDR = 8'h74;
   localparam logic [7:0] STAT_ADDR = 8'h78;
   // Configuration register bit positions.
   localparam int CFG_WAKE_REQ = 1;
   localparam int CFG_LINE12_REQ = 2;
   localparam int CFG_KBC_STRAP = 3;
   localparam int CFG_KEY_LOCK = 4;
   localparam logic [7:0] CFG_WMASK = 8'h16;
   localparam logic [7:0] CFG_RESET = 8'h00;
   // USB and pin control register bit positions.
   localparam int USB_EN = 0;
   localparam int USB_P0 = 1;
   localparam int USB_P1 = 2;
   localparam int USB_IRQ_PAIR = 3;
   localparam int USB_SLEEP = 4;
   localparam int USB_GP_OUT = 5;
   localparam int USB_GP_OE = 6;
   localparam logic [6:0] USB_RESET = 7'h00;
   // Shared pad indices.
   localparam int PIN_GENERAL0 = 0;
   localparam int PIN_WAKE0 = 1;
   localparam int PIN_LINE1 = 2;
   localparam int PIN_LINE12 = 3;
   localparam int PIN_CODE0 = 4;
   localparam int PIN_ACK3 = 7;
   localparam int PIN_ACK5 = 8;
   localparam int PIN_ACK6 = 9;
   localparam int PIN_ACK7 = 10;
   localparam int PIN_N = 11;
   // Code driven on the encoded acknowledge when no channel is acknowledged.
   localparam logic [2:0] CODE_IDLE = 3'h4;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // Register selector codes.
   localparam logic [1:0] SEL_NONE = 2'h0;
   localparam logic [1:0] SEL_CFG = 2'h1;
   localparam logic [1:0] SEL_USB = 2'h2;
   localparam logic [1:0] SEL_STAT = 2'h3;

   typedef struct packed {
      logic keyboard_controller;
      logic mouse;
      logic sio;
   } spm_straps_t;

   localparam spm_straps_t STRAPS_RESET = 3'h7;

   typedef struct packed {
      logic [PIN_N-1:0] o;
      logic [PIN_N-1:0] oe;
   } spm_pads_t;

   typedef struct packed {
      logic keyboard_data;
      logic keyboard_clock;
      logic mouse_data;
      logic mouse_clock;
      logic line1_to_pic;
      logic line12_to_pic;
      logic board_dma_req0;
      logic [1:0] board_irq_pair;
      logic wake0;
      logic general0_in;
      logic [1:0] usb_port_on;
      logic kbc_internal;
      logic mouse_active;
      logic superio_present;
   } spm_side_t;

   localparam spm_side_t SIDE_RESET = 16'hf000;
endpackage : spm_pkg

/* rtl/spm_top.sv */
// Strap capture at bus reset release and shared pin function selection.
`timescale 1ns/100ps
// What this block does
// RL1 - Straps are captured on the first clock after bus reset releases.
// RL2 - Keyboard strap low enables internal controller; captured value reads at 70h bit 3.
// RL3 - Internal controller: encoded acknowledge code out, ack 3 and 5 pins carry keyboard.
// RL4 - General pin 0 carries keyboard lock when 70h bit 4 set, else software pin.
// RL5 - Mouse strap low disables mouse support, high enables it.
// RL6 - Mouse active needs internal controller; wake 0 becomes data, irq line 1 clock.
// RL7 - Mouse interrupt 12 is internal; irq line 12 pin becomes DMA request 0 if enabled.
// RL8 - Without mouse, wake 0 pin serves as DMA request 0 when 70h bit 1 set.
// RL9 - Super I/O strap low marks external super I/O present, high absent.
// RL10 - Software enables USB and each port; enabled ports gate the irq line 12 DMA request and ack 6/7 pin reuse.
// RL11 - USB port 1 enabled lets ack 6 and 7 pins become board interrupt pair.
// RL12 - Ack 7 pin may be programmed as the hotkey sleep event output.
// RL13 - Captured straps hold until the next bus reset.
module spm_top (
   // Clock and bus reset.
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite slave.
   input wire logic [31:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [31:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   // Strap levels.
   input wire logic kbc_select_strap,
   input wire logic mouse_enable_strap,
   input wire logic superio_select_strap,
   // Internal functions feeding the pins.
   input wire logic [7:0] dma_ack_n,
   input wire logic [1:0] kbd_drive_low,
   input wire logic [1:0] mouse_drive_low,
   input wire logic kbd_irq,
   input wire logic mouse_irq,
   input wire logic keyboard_lock_n,
   input wire logic hotkey_sleep_event,
   // Shared pads.
   input wire logic [spm_pkg::PIN_N-1:0] pad_in,
   output spm_pkg::spm_pads_t pads,
   // Signals handed to internal functions.
   output spm_pkg::spm_side_t side
);
   typedef struct packed {
      spm_pkg::spm_straps_t straps;
      logic armed;
      logic [7:0] cfg;
      logic [6:0] usb;
      spm_pkg::spm_pads_t pads;
      spm_pkg::spm_side_t side;
      logic aw_got;
      logic [1:0] aw_sel;
      logic w_got;
      logic [7:0] w_byte;
      logic w_en;
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [1:0] rresp;
      logic [31:0] rdata;
   } spm_state_t;

   spm_state_t st;
   spm_state_t next_st;
   logic kbc_int;
   logic mouse_act;
   logic u0;
   logic u1;
   logic [1:0] rsel;

   function automatic logic [1:0] decode(input logic [31:0] a);
      logic [1:0] s;
      s = spm_pkg::SEL_NONE;
      if (a[31:8] == 24'h000000 && a[1:0] == 2'h0) begin
         case (a[7:0])
            spm_pkg::CFG_ADDR: s = spm_pkg::SEL_CFG;
            spm_pkg::USB_ADDR: s = spm_pkg::SEL_USB;
            spm_pkg::STAT_ADDR: s = spm_pkg::SEL_STAT;
            default: s = spm_pkg::SEL_NONE;
         endcase
      end
      return s;
   endfunction : decode

   // Lowest acknowledged channel wins; channel 4 is never presented.
   function automatic logic [2:0] encode(input logic [7:0] ack_n);
      logic [2:0] c;
      c = spm_pkg::CODE_IDLE;
      for (int i = 7; i >= 0; i--) begin
         if (!ack_n[i] && i != 4) begin
            c = 3'(i);
         end
      end
      return c;
   endfunction : encode

   assign kbc_int = !st.straps.keyboard_controller; // see RL2
   assign mouse_act = kbc_int && st.straps.mouse; // see RL5 see RL6
   assign u0 = st.usb[spm_pkg::USB_EN] && st.usb[spm_pkg::USB_P0]; // see RL10
   assign u1 = st.usb[spm_pkg::USB_EN] && st.usb[spm_pkg::USB_P1]; // see RL10
   assign rsel = decode(araddr);

   always_comb begin
      next_st = st;
      // Straps latch once after release and then stay put.
      if (st.armed) begin
         next_st.straps = '{keyboard_controller: kbc_select_strap, mouse: mouse_enable_strap,
                            sio: superio_select_strap}; // see RL1
         next_st.armed = 1'b0; // see RL13
      end

      // Write channel: address and data in either order.
      if (awvalid && st.awready) begin
         next_st.aw_got = 1'b1;
         next_st.aw_sel = decode(awaddr);
      end
      if (wvalid && st.wready) begin
         next_st.w_got = 1'b1;
         next_st.w_byte = wdata[7:0];
         next_st.w_en = wstrb[0];
      end
      if (st.bvalid && bready) begin
         next_st.bvalid = 1'b0;
      end
      if (st.aw_got && st.w_got && !st.bvalid) begin
         next_st.aw_got = 1'b0;
         next_st.w_got = 1'b0;
         next_st.bvalid = 1'b1;
         next_st.bresp = (st.aw_sel == spm_pkg::SEL_NONE) ? spm_pkg::RESP_SLVERR
                                                          : spm_pkg::RESP_OKAY;
         if (st.w_en && st.aw_sel == spm_pkg::SEL_CFG) begin
            next_st.cfg = st.w_byte & spm_pkg::CFG_WMASK;
         end
         if (st.w_en && st.aw_sel == spm_pkg::SEL_USB) begin
            next_st.usb = st.w_byte[6:0]; // see RL10
         end
      end
      next_st.awready = !next_st.aw_got && !next_st.bvalid;
      next_st.wready = !next_st.w_got && !next_st.bvalid;

      // Read channel.
      if (st.rvalid && rready) begin
         next_st.rvalid = 1'b0;
      end
      if (arvalid && st.arready) begin
         next_st.rvalid = 1'b1;
         next_st.rresp = spm_pkg::RESP_OKAY;
         next_st.rdata = 32'h00000000;
         case (rsel)
            spm_pkg::SEL_CFG: begin
               next_st.rdata[7:0] = st.cfg;
               next_st.rdata[spm_pkg::CFG_KBC_STRAP] = st.straps.keyboard_controller; // see RL2
            end
            spm_pkg::SEL_USB: next_st.rdata[6:0] = st.usb;
            spm_pkg::SEL_STAT: begin
               next_st.rdata[2:0] = st.straps;
               next_st.rdata[3] = kbc_int;
               next_st.rdata[4] = mouse_act;
               next_st.rdata[5] = !st.straps.sio;
               next_st.rdata[18:8] = pad_in;
            end
            default: next_st.rresp = spm_pkg::RESP_SLVERR;
         endcase
      end
      next_st.arready = !next_st.rvalid;

      // Pin functions.
      next_st.pads = '0;
      next_st.side = spm_pkg::SIDE_RESET;
      next_st.side.kbc_internal = kbc_int;
      next_st.side.mouse_active = mouse_act;
      next_st.side.superio_present = !st.straps.sio; // see RL9
      next_st.side.usb_port_on = {u1, u0}; // see RL10
      next_st.side.general0_in = pad_in[spm_pkg::PIN_GENERAL0];
      if (st.cfg[spm_pkg::CFG_KEY_LOCK]) begin
         next_st.pads.o[spm_pkg::PIN_GENERAL0] = keyboard_lock_n; // see RL4
         next_st.pads.oe[spm_pkg::PIN_GENERAL0] = 1'b1;
      end else begin
         next_st.pads.o[spm_pkg::PIN_GENERAL0] = st.usb[spm_pkg::USB_GP_OUT]; // see RL4
         next_st.pads.oe[spm_pkg::PIN_GENERAL0] = st.usb[spm_pkg::USB_GP_OE];
      end
      next_st.pads.oe[spm_pkg::PIN_CODE0 +: 3] = 3'h7;
      next_st.pads.oe[spm_pkg::PIN_ACK6] = 1'b1;
      next_st.pads.oe[spm_pkg::PIN_ACK7] = 1'b1;
      if (kbc_int) begin
         next_st.pads.o[spm_pkg::PIN_CODE0 +: 3] = encode(dma_ack_n); // see RL3
         // Keyboard lines are open drain: drive low or release.
         next_st.pads.oe[spm_pkg::PIN_ACK3] = kbd_drive_low[0]; // see RL3
         next_st.pads.oe[spm_pkg::PIN_ACK5] = kbd_drive_low[1];
         next_st.side.keyboard_data = pad_in[spm_pkg::PIN_ACK3];
         next_st.side.keyboard_clock = pad_in[spm_pkg::PIN_ACK5];
         next_st.pads.o[spm_pkg::PIN_ACK6] = 1'b1;
         next_st.pads.o[spm_pkg::PIN_ACK7] = 1'b1;
      end else begin
         next_st.pads.o[spm_pkg::PIN_CODE0 +: 3] = dma_ack_n[2:0];
         next_st.pads.o[spm_pkg::PIN_ACK3] = dma_ack_n[3];
         next_st.pads.o[spm_pkg::PIN_ACK5] = dma_ack_n[5];
         next_st.pads.oe[spm_pkg::PIN_ACK3] = 1'b1;
         next_st.pads.oe[spm_pkg::PIN_ACK5] = 1'b1;
         next_st.pads.o[spm_pkg::PIN_ACK6] = dma_ack_n[6];
         next_st.pads.o[spm_pkg::PIN_ACK7] = dma_ack_n[7];
      end
      next_st.side.line1_to_pic = kbc_int ? kbd_irq : pad_in[spm_pkg::PIN_LINE1];
      if (mouse_act) begin
         next_st.pads.oe[spm_pkg::PIN_WAKE0] = mouse_drive_low[0]; // see RL6
         next_st.pads.oe[spm_pkg::PIN_LINE1] = mouse_drive_low[1]; // see RL6
         next_st.side.mouse_data = pad_in[spm_pkg::PIN_WAKE0];
         next_st.side.mouse_clock = pad_in[spm_pkg::PIN_LINE1];
         next_st.side.line12_to_pic = mouse_irq; // see RL7
         next_st.side.board_dma_req0 = st.cfg[spm_pkg::CFG_LINE12_REQ] && u0
                                       && pad_in[spm_pkg::PIN_LINE12]; // see RL7
      end else begin
         next_st.side.line12_to_pic = pad_in[spm_pkg::PIN_LINE12];
         if (st.cfg[spm_pkg::CFG_WAKE_REQ]) begin
            next_st.side.board_dma_req0 = pad_in[spm_pkg::PIN_WAKE0]; // see RL8
         end else begin
            next_st.side.wake0 = pad_in[spm_pkg::PIN_WAKE0];
         end
      end
      if (u1 && st.usb[spm_pkg::USB_IRQ_PAIR]) begin
         next_st.pads.oe[spm_pkg::PIN_ACK6] = 1'b0; // see RL11
         next_st.pads.oe[spm_pkg::PIN_ACK7] = 1'b0;
         next_st.side.board_irq_pair = pad_in[spm_pkg::PIN_ACK7 -: 2];
      end
      // Sleep output takes the ack 7 pin over any other use.
      if (st.usb[spm_pkg::USB_SLEEP]) begin
         next_st.pads.o[spm_pkg::PIN_ACK7] = hotkey_sleep_event; // see RL12
         next_st.pads.oe[spm_pkg::PIN_ACK7] = 1'b1;
         next_st.side.board_irq_pair[1] = 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st <= '0;
         st.straps <= spm_pkg::STRAPS_RESET;
         st.armed <= 1'b1;
         st.cfg <= spm_pkg::CFG_RESET;
         st.usb <= spm_pkg::USB_RESET;
         st.side <= spm_pkg::SIDE_RESET;
      end else begin
         st <= next_st;
      end
   end

   assign awready = st.awready;
   assign wready = st.wready;
   assign bvalid = st.bvalid;
   assign bresp = st.bresp;
   assign arready = st.arready;
   assign rvalid = st.rvalid;
   assign rresp = st.rresp;
   assign rdata = st.rdata;
   assign pads = st.pads;
   assign side = st.side;

   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   sequence s_release;
      !$past(aresetn) && aresetn;
   endsequence

   chk_strap_capture: assert property (s_release |=> st.straps == // see RL1
      $past({kbc_select_strap, mouse_enable_strap, superio_select_strap}))
      else $error("straps not captured at reset release");
   chk_strap_hold: assert property (!st.armed |=> $stable(st.straps)) // see RL13
      else $error("captured straps changed");
   chk_kbc_readback: assert property (arvalid && arready && // see RL2
      araddr == 32'h00000070 |=> rvalid && rdata[3] == st.straps.keyboard_controller)
      else $error("keyboard strap readback wrong");
   chk_ack_encode: assert property (kbc_int && dma_ack_n == 8'hf7 |=> // see RL3
      pads.o[6:4] == 3'h3 && pads.oe[6:4] == 3'h7)
      else $error("encoded acknowledge wrong");
   chk_lock_pin: assert property (st.cfg[4] |=> // see RL4
      pads.oe[0] && pads.o[0] == $past(keyboard_lock_n))
      else $error("keyboard lock not on general pin 0");
   chk_mouse_off: assert property (!st.straps.mouse ##1 !st.straps.mouse |-> // see RL5
      !side.mouse_active && !pads.oe[1])
      else $error("mouse pins active without strap");
   chk_mouse_pins: assert property (mouse_act |=> // see RL6
      pads.oe[2] == $past(mouse_drive_low[1]) && side.mouse_active)
      else $error("mouse clock pin wrong");
   chk_line12_request: assert property (mouse_act && st.cfg[2] && u0 |=> // see RL7
      side.board_dma_req0 == $past(pad_in[3]) && side.line12_to_pic == $past(mouse_irq))
      else $error("irq line 12 pin reuse wrong");
   chk_wake_request: assert property (!mouse_act && st.cfg[1] |=> // see RL8
      side.board_dma_req0 == $past(pad_in[1]) && !side.wake0)
      else $error("wake 0 not used as dma request");
   chk_superio: assert property (!st.armed |=> side.superio_present == !st.straps.sio) // see RL9
      else $error("super io flag wrong");
   chk_usb_ports: assert property (1'b1 |=> side.usb_port_on == // see RL10
      {$past(u1), $past(u0)})
      else $error("usb port state wrong");
   chk_irq_pair: assert property (u1 && st.usb[3] && !st.usb[4] |=> // see RL11
      !pads.oe[9] && side.board_irq_pair == $past(pad_in[10:9]))
      else $error("board irq pair wrong");
   chk_sleep_out: assert property (st.usb[4] |=> pads.oe[10] && // see RL12
      pads.o[10] == $past(hotkey_sleep_event))
      else $error("sleep event not driven");
endmodule : spm_top

/* verification/spm_board.sv */
// Board model: strap resistors and the peripherals on the shared pads.
`timescale 1ns/100ps
module spm_board (
   // Clock and bus reset.
   input wire logic aclk,
   input wire logic aresetn,
   // Strap and peripheral levels chosen by the bench.
   input wire logic [2:0] strap_set,
   input wire logic [10:0] ext_level,
   // Pads of the block.
   input wire spm_pkg::spm_pads_t pads,
   output logic [2:0] strap_pin,
   output logic [10:0] pad_in
);
   logic held;
   always_ff @(posedge aclk) begin
      held <= aresetn;
   end
   // After release the strap pins carry other traffic, so their level flips.
   assign strap_pin = held ? ~strap_set : strap_set;
   // A pad the block drives shows its level, any other the peripheral's.
   assign pad_in = (pads.oe & pads.o) | (~pads.oe & ext_level);
endmodule : spm_board

/* verification/spm_top_tb.sv */
// Self-checking testbench for the strap latch and pin function mux.
`timescale 1ns/100ps
module spm_top_tb;
   localparam logic [31:0] A_CFG = {24'h0, spm_pkg::CFG_ADDR};
   localparam logic [31:0] A_USB = {24'h0, spm_pkg::USB_ADDR};
   localparam logic [31:0] A_STAT = {24'h0, spm_pkg::STAT_ADDR};
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [31:0] awaddr = 32'h0;
   logic [31:0] wdata = 32'h0;
   logic [31:0] araddr = 32'h0;
   logic [31:0] rdata, rd;
   logic awvalid = 1'b0;
   logic wvalid = 1'b0;
   logic arvalid = 1'b0;
   logic bready = 1'b1;
   logic rready = 1'b1;
   logic [3:0] wstrb = 4'hf;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp, resp;
   logic [1:0] kbd_drive_low = 2'h0;
   logic [1:0] mouse_drive_low = 2'h0;
   logic [7:0] dma_ack_n = 8'hff;
   logic kbd_irq = 1'b0;
   logic mouse_irq = 1'b0;
   logic keyboard_lock_n = 1'b1;
   logic hotkey_sleep_event = 1'b0;
   logic [2:0] strap_set = 3'h7;
   logic [2:0] strap_pin;
   logic [10:0] ext_level = 11'h7ff;
   logic [10:0] pad_in;
   spm_pkg::spm_pads_t pads;
   spm_pkg::spm_side_t side;
   int err_total = 0;
   int samples_checked = 0;
   int cycles = 0;

   spm_top dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
      .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .kbc_select_strap(strap_pin[2]), .mouse_enable_strap(strap_pin[1]),
      .superio_select_strap(strap_pin[0]), .dma_ack_n(dma_ack_n),
      .kbd_drive_low(kbd_drive_low), .mouse_drive_low(mouse_drive_low), .kbd_irq(kbd_irq),
      .mouse_irq(mouse_irq), .keyboard_lock_n(keyboard_lock_n),
      .hotkey_sleep_event(hotkey_sleep_event), .pad_in(pad_in), .pads(pads), .side(side));
   spm_board board (.aclk(aclk), .aresetn(aresetn), .strap_set(strap_set),
      .ext_level(ext_level), .pads(pads), .strap_pin(strap_pin), .pad_in(pad_in));

   initial begin
      forever #20 aclk = ~aclk;
   end

   task automatic stop_test;
      $display("Checks %0d, mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : stop_test

   always @(posedge aclk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         err_total++;
         stop_test();
      end
   end

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      logic aw_ok, w_ok;
      aw_ok = 1'b0;
      w_ok = 1'b0;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      while (!(aw_ok && w_ok)) begin
         @(posedge aclk);
         if (!aw_ok && awready === 1'b1) begin
            aw_ok = 1'b1;
            awvalid <= 1'b0;
         end
         if (!w_ok && wready === 1'b1) begin
            w_ok = 1'b1;
            wvalid <= 1'b0;
         end
      end
      do @(posedge aclk); while (bvalid !== 1'b1);
      resp = bresp;
   endtask : wr

   task automatic rd32(input logic [31:0] a);
      araddr <= a;
      arvalid <= 1'b1;
      do @(posedge aclk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge aclk); while (rvalid !== 1'b1);
      rd = rdata;
      resp = rresp;
   endtask : rd32

   // Pad levels loop back through the board, so side outputs lag inputs by two edges.
   task automatic settle;
      repeat (3) @(posedge aclk);
   endtask : settle

   task automatic boot(input logic [2:0] s);
      strap_set <= s;
      aresetn <= 1'b0;
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (3) @(posedge aclk);
   endtask : boot

   task automatic t_straps;
      for (int s = 0; s < 8; s++) begin
         boot(s[2:0]);
         rd32(A_STAT);
         check("status", rd & 32'h3f, {26'h0, ~s[0], ~s[2] & s[1], ~s[2], s[2:0]});
         rd32(A_CFG);
         check("cfg strap", rd, {28'h0, s[2], 3'h0});
         check("side", {29'h0, side[2:0]}, {29'h0, ~s[2], ~s[2] & s[1], ~s[0]});
      end
      $display("Test straps done");
   endtask : t_straps

   task automatic t_regs;
      boot(3'h3);
      wr(A_CFG, 32'hffffffff);
      check("cfg resp", {30'h0, resp}, {30'h0, spm_pkg::RESP_OKAY});
      rd32(A_CFG);
      check("cfg", rd, 32'h16);
      wstrb <= 4'he;
      wr(A_CFG, 32'h0);
      wstrb <= 4'hf;
      rd32(A_CFG);
      check("cfg strobe", rd, 32'h16);
      wr(A_USB, 32'h7f);
      rd32(A_USB);
      check("ctrl", rd, 32'h7f);
      wr(32'h7c, 32'h1);
      check("bad write", {30'h0, resp}, {30'h0, spm_pkg::RESP_SLVERR});
      rd32(32'h7c);
      check("bad read", {30'h0, resp}, {30'h0, spm_pkg::RESP_SLVERR});
      wr(A_STAT, 32'h0);
      rd32(A_STAT);
      check("status ro", rd & 32'h3f, 32'h1b);
      wr(A_CFG, 32'h0);
      wr(A_USB, 32'h0);
      $display("Test registers done");
   endtask : t_regs

   task automatic t_kbd;
      dma_ack_n <= 8'hf7;
      kbd_drive_low <= 2'h1;
      mouse_drive_low <= 2'h2;
      kbd_irq <= 1'b1;
      settle();
      check("ack code", {26'h0, pads.oe[6:4], pads.o[6:4]}, 32'h3b);
      check("kbd pads", {28'h0, pads.oe[8:7], pads.o[8:7]}, 32'h4);
      check("kbd side", {30'h0, side.keyboard_data, side.keyboard_clock}, 32'h1);
      check("mouse oe", {30'h0, pads.oe[2:1]}, 32'h2);
      check("mouse side", {30'h0, side.mouse_data, side.mouse_clock}, 32'h2);
      check("irqs", {30'h0, side.line1_to_pic, side.line12_to_pic}, 32'h2);
      dma_ack_n <= 8'hff;
      settle();
      check("ack idle", {29'h0, pads.o[6:4]}, {29'h0, spm_pkg::CODE_IDLE});
      $display("Test keyboard done");
   endtask : t_kbd

   task automatic t_gpio;
      wr(A_CFG, 32'h10);
      keyboard_lock_n <= 1'b0;
      settle();
      check("lock low", {30'h0, pads.oe[0], pads.o[0]}, 32'h2);
      keyboard_lock_n <= 1'b1;
      settle();
      check("lock high", {30'h0, pads.oe[0], pads.o[0]}, 32'h3);
      wr(A_CFG, 32'h0);
      wr(A_USB, 32'h40);
      settle();
      check("gpio", {29'h0, pads.oe[0], pads.o[0], side.general0_in}, 32'h4);
      wr(A_USB, 32'h0);
      settle();
      check("gpio in", {31'h0, side.general0_in}, 32'h1);
      $display("Test gpio done");
   endtask : t_gpio

   task automatic t_dmareq;
      wr(A_USB, 32'h3);
      wr(A_CFG, 32'h4);
      ext_level <= 11'h008;
      settle();
      check("line12 req", {30'h0, side.usb_port_on[0], side.board_dma_req0}, 32'h3);
      ext_level <= 11'h7f7;
      settle();
      check("line12 req", {31'h0, side.board_dma_req0}, 32'h0);
      boot(3'h1);
      wr(A_CFG, 32'h2);
      ext_level <= 11'h002;
      settle();
      check("wake req", {30'h0, side.board_dma_req0, side.wake0}, 32'h2);
      ext_level <= 11'h7fd;
      settle();
      check("wake req", {31'h0, side.board_dma_req0}, 32'h0);
      $display("Test dma request done");
   endtask : t_dmareq

   task automatic t_usb;
      boot(3'h3);
      wr(A_USB, 32'hd);
      ext_level <= 11'h400;
      settle();
      check("irq pair", {28'h0, side.usb_port_on, side.board_irq_pair}, 32'ha);
      ext_level <= 11'h200;
      settle();
      check("irq pair", {28'h0, side.usb_port_on, side.board_irq_pair}, 32'h9);
      wr(A_USB, 32'h1d);
      hotkey_sleep_event <= 1'b1;
      settle();
      check("sleep", {29'h0, pads.oe[10], pads.o[10], side.board_irq_pair[1]}, 32'h6);
      $display("Test usb done");
   endtask : t_usb

   initial begin
      t_straps();
      t_regs();
      t_kbd();
      t_gpio();
      t_dmareq();
      t_usb();
      stop_test();
   end
endmodule : spm_top_tb
